// ===== rtl/xcmd_pkg.sv
package xcmd_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_COMMAND_ACK = 8'h07;
    localparam logic [7:0] OFF_EXTENDED_COMMAND = 8'h0F;
    localparam logic [7:0] OFF_PARAMETER_VALUE = 8'h10;
    localparam logic [15:0] REG_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Command field positions
    // ------------------------------------------------------------
    localparam int CODE_MSB = 15;
    localparam int CODE_LSB = 8;
    localparam int PNUM_MSB = 7;
    localparam int PNUM_LSB = 0;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CODE_WRITE_BASE = 8'h80;
    localparam logic [7:0] CODE_READ_BASE = 8'hA0;
    localparam logic [7:0] CODE_SERIAL1_WR = 8'h87;
    localparam logic [7:0] CODE_SERIAL2_WR = 8'h88;
    localparam logic [7:0] CODE_SERIAL1_RD = 8'hA7;
    localparam logic [7:0] CODE_SERIAL2_RD = 8'hA8;
    localparam logic [7:0] CODE_COUNTER_LO = 8'h8F;
    localparam logic [7:0] CODE_COUNTER_HI = 8'h90;
    localparam logic [7:0] CODE_RESERVED_A = 8'hAF;
    localparam logic [7:0] CODE_RESERVED_B = 8'hB0;
    localparam int NUM_POINTS = 14;

    // ------------------------------------------------------------
    // Parameter numbers
    // ------------------------------------------------------------
    localparam logic [7:0] PAR_ENABLE = 8'h01;
    localparam logic [7:0] PAR_IO_TYPE = 8'h02;
    localparam logic [7:0] PAR_DUTY_CYCLE = 8'h04;
    localparam logic [7:0] PAR_THRESHOLD = 8'h08;
    localparam logic [7:0] PAR_HYSTERESIS = 8'h09;
    localparam logic [7:0] PAR_REPORT_TYPE = 8'h0E;
    localparam logic [7:0] PAR_DELTA = 8'h0F;
    localparam logic [7:0] PAR_INVERT = 8'h10;
    localparam logic [7:0] PAR_DEFAULT = 8'h11;
    localparam logic [7:0] PAR_LOW_PASS = 8'h12;
    localparam logic [7:0] PAR_SENSOR_CFG = 8'h14;
    localparam logic [7:0] PAR_COUNTER_EN = 8'h18;

    // ------------------------------------------------------------
    // Field layouts and reset values
    // ------------------------------------------------------------
    localparam int LPF_MEDIAN_BIT = 7;
    localparam int DEF_BIT_POWERUP = 1;
    localparam int DEF_BIT_SYNC = 2;
    localparam int DEF_BIT_HOST = 3;
    localparam int DEF_BIT_GW = 4;
    localparam int DEF_BIT_NODE = 5;
    localparam logic [15:0] DEFAULT_HOLD_LAST = 16'hFFFF;
    localparam logic [1:0] RPT_DISCRETE = 2'h0;
    localparam logic [1:0] RPT_ANALOG = 2'h1;
    localparam logic [1:0] RPT_DOUBLE = 2'h2;
    localparam logic [1:0] CNT_OFF = 2'h0;
    localparam logic [1:0] CNT_16 = 2'h1;
    localparam logic [1:0] CNT_32 = 2'h2;
    localparam int DUTY_TICK_MS = 62;
    localparam int DUTY_TICK_US = 62500;
    localparam int CLK_MHZ = 25;
    localparam int DUTY_TICK_CYC = DUTY_TICK_US * CLK_MHZ;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_NONE = 3'b001,
        CMD_WRITE = 3'b010,
        CMD_READ = 3'b100
    } cmd_kind_e;

    typedef struct packed {
        logic enable;
        logic [7:0] io_type;
        logic [15:0] duty_cycle;
        logic [15:0] threshold;
        logic [15:0] hysteresis;
        logic [1:0] report_type;
        logic [15:0] delta;
        logic invert;
        logic [15:0] default_value;
        logic [7:0] low_pass;
        logic [15:0] sensor_cfg;
        logic [1:0] counter_en;
    } point_cfg_s;

    typedef struct packed {
        logic power_up;
        logic sync_loss_condition;
        logic host_link_fail;
        logic gw_link_fail;
        logic node_link_fail;
    } fail_events_s;

endpackage : xcmd_pkg

// ===== rtl/point_output.sv
`timescale 1ns/100ps
module point_output #(
    parameter int TICK_CYC = 1562500
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire xcmd_pkg::point_cfg_s cfg,
    input wire xcmd_pkg::fail_events_s events,
    input wire logic cmd_value,
    input wire logic gw_fail_point,
    input wire logic sensed_in,
    input wire logic [15:0] analog_in,
    output logic out_level,
    output logic eval_level
);
    import xcmd_pkg::*;

    logic state_q;
    logic applied_q;
    logic [$clog2(TICK_CYC+1)-1:0] tick_q;
    logic [3:0] slot_q;
    logic analog_on_q;
    logic hold_last;
    logic force_default;

    // ------------------------------------------------------------
    // Output state and failure defaults
    // ------------------------------------------------------------
    assign hold_last = (cfg.default_value == DEFAULT_HOLD_LAST);
    assign force_default = (events.sync_loss_condition && cfg.default_value[DEF_BIT_SYNC])
        || (events.host_link_fail && cfg.default_value[DEF_BIT_HOST])
        || (events.gw_link_fail && gw_fail_point && cfg.default_value[DEF_BIT_GW])
        || (events.node_link_fail && cfg.default_value[DEF_BIT_NODE]);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= 1'b0;
        end else if (events.power_up) begin
            state_q <= cfg.default_value[DEF_BIT_POWERUP] ? cfg.default_value[0] : 1'b0;
        end else if (force_default && !hold_last) begin
            state_q <= cfg.default_value[0];
        end else begin
            state_q <= cmd_value;
        end
    end

    // ------------------------------------------------------------
    // Duty cycle in sixteenths of a second
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tick_q <= '0;
            slot_q <= 4'h0;
        end else if (tick_q == ($bits(tick_q))'(TICK_CYC - 1)) begin
            tick_q <= '0;
            slot_q <= slot_q + 4'h1;
        end else begin
            tick_q <= tick_q + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            out_level <= 1'b0;
        end else if (!cfg.enable) begin
            out_level <= 1'b0;
        end else if (cfg.duty_cycle != 16'h0000) begin
            out_level <= state_q & cfg.duty_cycle[slot_q];
        end else begin
            out_level <= state_q;
        end
    end

    // ------------------------------------------------------------
    // Input evaluation with threshold and hysteresis
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            analog_on_q <= 1'b0;
        end else if (cfg.threshold == 16'h0000) begin
            analog_on_q <= 1'b0;
        end else if (analog_in >= cfg.threshold) begin
            analog_on_q <= 1'b1;
        end else if ({1'b0, analog_in} + {1'b0, cfg.hysteresis} < {1'b0, cfg.threshold}) begin
            analog_on_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            eval_level <= 1'b0;
        end else if (cfg.report_type == RPT_DISCRETE) begin
            eval_level <= cfg.enable & (sensed_in ^ cfg.invert);
        end else begin
            eval_level <= cfg.enable & (analog_on_q ^ cfg.invert);
        end
    end

endmodule : point_output

// ===== rtl/io_param_extended_command_unit.sv
`timescale 1ns/100ps
module io_param_extended_command_unit #(
    parameter int TICK_CYC = xcmd_pkg::DUTY_TICK_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    input wire xcmd_pkg::fail_events_s events,
    input wire logic [xcmd_pkg::NUM_POINTS-1:0] gw_fail_mask,
    input wire logic [xcmd_pkg::NUM_POINTS-1:0] cmd_values,
    input wire logic [xcmd_pkg::NUM_POINTS-1:0] sensed_in,
    input wire logic [15:0] analog_in,
    input wire logic [15:0] counter_value,
    output logic [xcmd_pkg::NUM_POINTS-1:0] out_level,
    output logic [xcmd_pkg::NUM_POINTS-1:0] eval_level,
    output logic [xcmd_pkg::NUM_POINTS-1:0] median_en,
    output logic [2:0] filter_mag [xcmd_pkg::NUM_POINTS],
    output logic [15:0] counter_preset,
    output logic counter_lo_wr,
    output logic counter_hi_wr,
    output logic [1:0] serial_wr,
    output logic [15:0] serial_data,
    output logic cfg_error
);
    import xcmd_pkg::*;

    logic [15:0] command_q;
    logic [15:0] ack_q;
    logic [15:0] value_q;
    point_cfg_s cfg_q [NUM_POINTS];
    logic [15:0] serial_q [2];
    logic [7:0] code;
    logic [7:0] pnum;
    cmd_kind_e kind;
    logic [4:0] point;
    logic cmd_wr;
    logic [15:0] rd_value;

    // ------------------------------------------------------------
    // Command decoding
    // ------------------------------------------------------------
    function automatic logic point_valid(input logic [4:0] p);
        point_valid = (p >= 5'd1 && p <= 5'd6) || (p >= 5'd9 && p <= 5'd14);
    endfunction : point_valid

    function automatic cmd_kind_e decode_kind(input logic [7:0] c);
        if (c == CODE_RESERVED_A || c == CODE_RESERVED_B) begin
            decode_kind = CMD_NONE;
        end else if (c[7:5] == CODE_WRITE_BASE[7:5] && point_valid(c[4:0])) begin
            decode_kind = CMD_WRITE;
        end else if (c[7:5] == CODE_READ_BASE[7:5] && point_valid(c[4:0])) begin
            decode_kind = CMD_READ;
        end else if (c == CODE_SERIAL1_WR || c == CODE_SERIAL2_WR) begin
            decode_kind = CMD_WRITE;
        end else if (c == CODE_SERIAL1_RD || c == CODE_SERIAL2_RD) begin
            decode_kind = CMD_READ;
        end else if (c == CODE_COUNTER_LO || c == CODE_COUNTER_HI) begin
            decode_kind = CMD_WRITE;
        end else begin
            decode_kind = CMD_NONE;
        end
    endfunction : decode_kind

    assign cmd_wr = reg_wr && (reg_addr == OFF_EXTENDED_COMMAND);
    assign code = reg_wdata[CODE_MSB:CODE_LSB];
    assign pnum = reg_wdata[PNUM_MSB:PNUM_LSB];
    assign kind = cmd_wr ? decode_kind(code) : CMD_NONE;
    assign point = code[4:0];

    // ------------------------------------------------------------
    // Host registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            command_q <= REG_RESET;
        end else if (cmd_wr) begin
            command_q <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ack_q <= REG_RESET;
        end else if (kind != CMD_NONE) begin
            ack_q <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            value_q <= REG_RESET;
        end else if (kind == CMD_READ) begin
            value_q <= rd_value;
        end else if (reg_wr && reg_addr == OFF_PARAMETER_VALUE) begin
            value_q <= reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // Parameter read mux
    // ------------------------------------------------------------
    always_comb begin
        rd_value = 16'h0000;
        if (code == CODE_SERIAL1_RD) begin
            rd_value = serial_q[0];
        end else if (code == CODE_SERIAL2_RD) begin
            rd_value = serial_q[1];
        end else if (point_valid(point)) begin
            case (pnum)
                PAR_ENABLE: rd_value = {15'h0000, cfg_q[point-1].enable};
                PAR_IO_TYPE: rd_value = {8'h00, cfg_q[point-1].io_type};
                PAR_DUTY_CYCLE: rd_value = cfg_q[point-1].duty_cycle;
                PAR_THRESHOLD: rd_value = cfg_q[point-1].threshold;
                PAR_HYSTERESIS: rd_value = cfg_q[point-1].hysteresis;
                PAR_REPORT_TYPE: rd_value = {14'h0000, cfg_q[point-1].report_type};
                PAR_DELTA: rd_value = cfg_q[point-1].delta;
                PAR_INVERT: rd_value = {15'h0000, cfg_q[point-1].invert};
                PAR_DEFAULT: rd_value = cfg_q[point-1].default_value;
                PAR_LOW_PASS: rd_value = {8'h00, cfg_q[point-1].low_pass};
                PAR_SENSOR_CFG: rd_value = cfg_q[point-1].sensor_cfg;
                PAR_COUNTER_EN: rd_value = {14'h0000, cfg_q[point-1].counter_en};
                default: rd_value = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_addr == OFF_COMMAND_ACK) begin
                reg_rdata <= ack_q;
            end else if (reg_addr == OFF_EXTENDED_COMMAND) begin
                reg_rdata <= command_q;
            end else if (reg_addr == OFF_PARAMETER_VALUE) begin
                reg_rdata <= value_q;
            end else begin
                reg_rdata <= 16'h0000;
            end
        end
    end

    // ------------------------------------------------------------
    // Serial and counter writes
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            serial_q[0] <= 16'h0000;
            serial_q[1] <= 16'h0000;
            serial_wr <= 2'b00;
            serial_data <= 16'h0000;
            counter_lo_wr <= 1'b0;
            counter_hi_wr <= 1'b0;
            counter_preset <= 16'h0000;
        end else begin
            serial_wr <= 2'b00;
            counter_lo_wr <= 1'b0;
            counter_hi_wr <= 1'b0;
            if (kind == CMD_WRITE && code == CODE_SERIAL1_WR) begin
                serial_q[0] <= value_q;
                serial_wr <= 2'b01;
                serial_data <= value_q;
            end else if (kind == CMD_WRITE && code == CODE_SERIAL2_WR) begin
                serial_q[1] <= value_q;
                serial_wr <= 2'b10;
                serial_data <= value_q;
            end else if (kind == CMD_WRITE && code == CODE_COUNTER_LO) begin
                counter_lo_wr <= 1'b1;
                counter_preset <= value_q;
            end else if (kind == CMD_WRITE && code == CODE_COUNTER_HI) begin
                counter_hi_wr <= 1'b1;
                counter_preset <= value_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Per-point parameter storage and output logic
    // ------------------------------------------------------------
    generate
        for (genvar i = 0; i < NUM_POINTS; i++) begin : g_point
            logic sel;
            assign sel = (kind == CMD_WRITE) && (code[7:5] == CODE_WRITE_BASE[7:5])
                && point_valid(point) && (point == 5'(i + 1));

            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    cfg_q[i] <= '0;
                    cfg_q[i].report_type <= RPT_ANALOG;
                end else if (sel) begin
                    case (pnum)
                        PAR_ENABLE: cfg_q[i].enable <= value_q[0];
                        PAR_IO_TYPE: cfg_q[i].io_type <= value_q[7:0];
                        PAR_DUTY_CYCLE: cfg_q[i].duty_cycle <= value_q;
                        PAR_THRESHOLD: cfg_q[i].threshold <= value_q;
                        PAR_HYSTERESIS: cfg_q[i].hysteresis <= value_q;
                        PAR_REPORT_TYPE: cfg_q[i].report_type <= value_q[1:0];
                        PAR_DELTA: cfg_q[i].delta <= value_q;
                        PAR_INVERT: cfg_q[i].invert <= value_q[0];
                        PAR_DEFAULT: cfg_q[i].default_value <= value_q;
                        PAR_LOW_PASS: cfg_q[i].low_pass <= value_q[7:0];
                        PAR_SENSOR_CFG: cfg_q[i].sensor_cfg <= value_q;
                        PAR_COUNTER_EN: cfg_q[i].counter_en <= value_q[1:0];
                        default: cfg_q[i].enable <= cfg_q[i].enable;
                    endcase
                end
            end

            assign median_en[i] = cfg_q[i].low_pass[LPF_MEDIAN_BIT];
            assign filter_mag[i] = cfg_q[i].low_pass[2:0];

            point_output #(
                .TICK_CYC(TICK_CYC)
            ) u_point (
                .ref_clk(ref_clk),
                .rst(rst),
                .cfg(cfg_q[i]),
                .events(events),
                .cmd_value(cmd_values[i]),
                .gw_fail_point(gw_fail_mask[i]),
                .sensed_in(sensed_in[i]),
                .analog_in(analog_in),
                .out_level(out_level[i]),
                .eval_level(eval_level[i])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Configuration consistency
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cfg_error <= 1'b0;
        end else begin
            cfg_error <= 1'b0;
            for (int k = 0; k < NUM_POINTS; k++) begin
                if (cfg_q[k].enable && cfg_q[k].io_type == 8'h00) begin
                    cfg_error <= 1'b1;
                end
                if (cfg_q[k].counter_en == CNT_16 && cfg_q[k].report_type != RPT_ANALOG) begin
                    cfg_error <= 1'b1;
                end
                if (cfg_q[k].counter_en == CNT_32 && cfg_q[k].report_type != RPT_DOUBLE) begin
                    cfg_error <= 1'b1;
                end
            end
        end
    end

endmodule : io_param_extended_command_unit

// ===== sim/xcmd_props.sv
`timescale 1ns/100ps
module xcmd_props
    import xcmd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic counter_lo_wr,
    input wire logic counter_hi_wr,
    input wire logic [1:0] serial_wr
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_cmd(logic [7:0] c);
        reg_wr && reg_addr == OFF_EXTENDED_COMMAND && reg_wdata[15:8] == c;
    endsequence
    a_rvalid_after_read: assert property (reg_rd |=> reg_rvalid)
        else $error("read strobe without valid");
    a_rvalid_needs_read: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("valid without read strobe");
    a_counter_low_pulse: assert property (s_cmd(CODE_COUNTER_LO) |-> ##[1:2] counter_lo_wr)
        else $error("counter low strobe missing");
    a_counter_high_pulse: assert property (s_cmd(CODE_COUNTER_HI) |-> ##[1:2] counter_hi_wr)
        else $error("counter high strobe missing");
    a_serial_one_pulse: assert property (s_cmd(CODE_SERIAL1_WR) |-> ##[1:2] serial_wr == 2'h1)
        else $error("serial one strobe missing");
    a_serial_two_pulse: assert property (s_cmd(CODE_SERIAL2_WR) |-> ##[1:2] serial_wr == 2'h2)
        else $error("serial two strobe missing");
    a_reserved_no_action: assert property (reg_wr && reg_addr == OFF_EXTENDED_COMMAND
        && (reg_wdata[15:8] == CODE_RESERVED_A || reg_wdata[15:8] == CODE_RESERVED_B)
        |=> (!counter_lo_wr && !counter_hi_wr && serial_wr == 2'h0) [*2])
        else $error("reserved code caused an action");
    a_unmapped_read_zero: assert property (reg_rd && reg_addr == 8'h20 |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
endmodule : xcmd_props
bind io_param_extended_command_unit xcmd_props u_props (.ref_clk, .rst, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .counter_lo_wr, .counter_hi_wr, .serial_wr);

// ===== sim/host_model.sv
`timescale 1ns/100ps
module host_model
    import xcmd_pkg::*;
(
    input wire logic ref_clk,
    output logic reg_wr = 1'b0,
    output logic reg_rd = 1'b0,
    output logic [7:0] reg_addr = 8'h00,
    output logic [15:0] reg_wdata = 16'h0000,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid
);
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge ref_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge ref_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge ref_clk);
        d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hXXXX;
        reg_rd = 1'b0;
    endtask : rd
    task automatic set(input logic [15:0] c, input logic [15:0] v);
        wr(OFF_PARAMETER_VALUE, v);
        wr(OFF_EXTENDED_COMMAND, c);
    endtask : set
    task automatic get(input logic [15:0] c, output logic [15:0] v);
        wr(OFF_EXTENDED_COMMAND, c);
        rd(OFF_PARAMETER_VALUE, v);
    endtask : get
endmodule : host_model

// ===== sim/tb_io_param_extended_command_unit.sv
`timescale 1ns/100ps
module tb_io_param_extended_command_unit;
    import xcmd_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, reg_wr, reg_rd, reg_rvalid, cfg_error;
    logic counter_lo_wr, counter_hi_wr;
    logic [7:0] reg_addr, pt;
    logic [15:0] reg_wdata, reg_rdata, counter_preset, serial_data, r, r0;
    logic [15:0] analog_in = 16'h0000;
    logic [1:0] serial_wr;
    logic [NUM_POINTS-1:0] gw_fail_mask = '0, cmd_values = '0, sensed_in = '0;
    logic [NUM_POINTS-1:0] out_level, eval_level, median_en;
    logic [2:0] filter_mag [NUM_POINTS];
    fail_events_s events = '0;
    int fails = 0, tests_run = 0;
    logic [7:0] pars [12] = '{PAR_ENABLE, PAR_IO_TYPE, PAR_DUTY_CYCLE, PAR_THRESHOLD,
        PAR_HYSTERESIS, PAR_REPORT_TYPE, PAR_DELTA, PAR_INVERT, PAR_DEFAULT, PAR_LOW_PASS,
        PAR_SENSOR_CFG, PAR_COUNTER_EN};
    logic [15:0] msk [12] = '{16'h0001, 16'h00FF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0003,
        16'hFFFF, 16'h0001, 16'hFFFF, 16'h00FF, 16'hFFFF, 16'h0003};
    always #20 ref_clk = ~ref_clk;
    io_param_extended_command_unit #(.TICK_CYC(4)) u_dut (.ref_clk, .rst, .reg_wr, .reg_rd,
        .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .events, .gw_fail_mask, .cmd_values,
        .sensed_in, .analog_in, .counter_value(analog_in), .out_level, .eval_level, .median_en,
        .filter_mag, .counter_preset, .counter_lo_wr, .counter_hi_wr, .serial_wr, .serial_data,
        .cfg_error);
    host_model u_host (.ref_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .reg_rvalid);
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test
    task automatic t_reset;
        u_host.rd(OFF_COMMAND_ACK, r);
        chk("ack reset", REG_RESET, r);
        u_host.rd(8'h20, r);
        chk("unmapped read", 16'h0000, r);
    endtask : t_reset
    task automatic t_params;
        foreach (pars[i]) begin
            u_host.set({8'h8E, pars[i]}, 16'hC3A5);
            u_host.rd(OFF_COMMAND_ACK, r);
            chk("write ack", {8'h8E, pars[i]}, r);
            u_host.get({8'hAE, pars[i]}, r);
            chk("param", 16'hC3A5 & msk[i], r);
        end
        chk("median", 16'h0001, {15'h0, median_en[13]});
        chk("magnitude", 16'h0005, {13'h0, filter_mag[13]});
        chk("cfg ok", 16'h0000, {15'h0, cfg_error});
        u_host.set({8'h8E, PAR_COUNTER_EN}, 16'h0002);
        u_host.get({8'hAE, PAR_INVERT}, r);
        chk("counter mode", 16'h0001, {15'h0, cfg_error});
        u_host.set({8'h8E, PAR_COUNTER_EN}, 16'h0000);
        u_host.get({8'hAE, PAR_ENABLE}, r);
        chk("value only", 16'h0001, r);
        chk("counter off", 16'h0000, {15'h0, cfg_error});
        foreach (pars[i]) begin
            pt = (i < 6) ? 8'(i + 1) : 8'(i + 3);
            u_host.set({CODE_WRITE_BASE + pt, PAR_ENABLE}, 16'h0001);
            u_host.get({CODE_READ_BASE + pt, PAR_ENABLE}, r);
            chk("point enable", 16'h0001, r);
        end
        chk("type missing", 16'h0001, {15'h0, cfg_error});
    endtask : t_params
    task automatic t_reserved;
        u_host.rd(OFF_COMMAND_ACK, r0);
        u_host.set({CODE_RESERVED_A, PAR_ENABLE}, 16'h0000);
        u_host.set({CODE_RESERVED_B, PAR_ENABLE}, 16'h0000);
        u_host.set({8'hA7 + 8'h1F, PAR_ENABLE}, 16'h0000);
        u_host.rd(OFF_COMMAND_ACK, r);
        chk("reserved ack", r0, r);
    endtask : t_reserved
    task automatic t_special;
        u_host.set({CODE_COUNTER_LO, 8'h00}, 16'h1234);
        chk("counter low", 16'h1234, counter_preset);
        u_host.set({CODE_COUNTER_HI, 8'h00}, 16'hBEEF);
        chk("counter high", 16'hBEEF, counter_preset);
        u_host.set({CODE_SERIAL2_WR, 8'h00}, 16'h0F0F);
        u_host.set({CODE_SERIAL1_WR, 8'h00}, 16'h5A5A);
        chk("serial data", 16'h5A5A, serial_data);
        u_host.get({CODE_SERIAL1_RD, 8'h00}, r);
        chk("serial read", 16'h5A5A, r);
        u_host.get({CODE_SERIAL2_RD, 8'h00}, r);
        chk("serial two read", 16'h0F0F, r);
    endtask : t_special
    task automatic t_outputs;
        int n = 0;
        u_host.set({8'h81, PAR_DEFAULT}, 16'h0034);
        cmd_values = '1;
        gw_fail_mask = '1;
        repeat (3) @(negedge ref_clk);
        chk("out enabled", 16'h1F3F, {3'h0, out_level[12:0]});
        events = 5'h08;
        repeat (3) @(negedge ref_clk);
        chk("out sync loss", 16'h1F3E, {3'h0, out_level[12:0]});
        events = 5'h02;
        repeat (3) @(negedge ref_clk);
        chk("out gateway fail", 16'h1F3E, {3'h0, out_level[12:0]});
        events = 5'h01;
        repeat (3) @(negedge ref_clk);
        chk("out node fail", 16'h1F3E, {3'h0, out_level[12:0]});
        events = 5'h04;
        repeat (3) @(negedge ref_clk);
        chk("out host fail off", 16'h1F3F, {3'h0, out_level[12:0]});
        events = 5'h10;
        repeat (3) @(negedge ref_clk);
        chk("out power up", 16'h0000, {3'h0, out_level[12:0]});
        events = 5'h00;
        u_host.set({8'h81, PAR_DUTY_CYCLE}, 16'h0001);
        repeat (64) begin
            @(negedge ref_clk);
            n += out_level[0];
        end
        chk("duty cycles", 16'h0004, 16'(n));
        u_host.set({8'h81, PAR_THRESHOLD}, 16'h0100);
        u_host.set({8'h81, PAR_HYSTERESIS}, 16'h0010);
        analog_in = 16'h0100;
        repeat (3) @(negedge ref_clk);
        chk("eval on", 16'h0001, {15'h0, eval_level[0]});
        analog_in = 16'h00F8;
        repeat (3) @(negedge ref_clk);
        chk("eval hold", 16'h0001, {15'h0, eval_level[0]});
        analog_in = 16'h00EF;
        repeat (3) @(negedge ref_clk);
        chk("eval off", 16'h0000, {15'h0, eval_level[0]});
        u_host.set({8'h81, PAR_INVERT}, 16'h0001);
        repeat (2) @(negedge ref_clk);
        chk("eval invert", 16'h0001, {15'h0, eval_level[0]});
    endtask : t_outputs
    initial begin
        repeat (6) @(negedge ref_clk);
        rst = 1'b0;
        t_reset();
        t_params();
        t_reserved();
        t_special();
        t_outputs();
        stop_test();
    end
    initial begin
        #200000;
        fails++;
        stop_test();
    end
endmodule : tb_io_param_extended_command_unit
